// [design/adc_result_sequence_status_regs.sv]
// Sequencing status, result, last result and bias trim register bank
//
// Operation
// - Busy sets when sequencing enabled or restarted
// - Busy clears when sequencing is disabled
// - Pending bit per target until updated
// - Read-only result register at 0x40
// - Plain conversion gives 12 bits, adjustable
// - Left adjust: high byte [15:8], rest [7:4]
// - Right adjust without averaging: bits [11:0]
// - Oversampled result placed by averaging settings
// - Read-only last result register at 0x44
// - Three 3-bit bias trim fields, reset zero
// - Trim writes only when disabled, unprotected
// - Sequence data goes to first pending target
// - Result read or write-one clears ready
// - Unread result overwritten sets overrun
// - Auto-start after sequence unless event start
//
// Our own choice: the plain strobed port.
module adc_result_sequence_status_regs (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// Register port
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        we_i,
	input  wire logic        re_i,
	output      logic [31:0] rdata_o,
	// Converter core side
	input  wire logic        conv_valid_i,  // New value this cycle
	input  wire logic [15:0] conv_data_i,   // Raw value or sum
	input  wire logic        start_event_i, // Event system start
	output      logic        conv_start_o,  // One-cycle start
	output      logic        tgt_wr_o,      // Target update pulse
	output      logic [3:0]  tgt_sel_o,     // Target number
	output      logic [31:0] tgt_data_o,    // Target update word
	// Settings seen by the analog side, then the ready and overrun flags
	output      logic        enable_o,
	output      logic        left_adjust_o,
	output      logic [2:0]  reference_buffer_bias_o,
	output      logic [2:0]  ladder_amplifier_bias_o,
	output      logic [2:0]  comparator_bias_o,
	output      logic        result_ready_flag_o,
	output      logic        overrun_o
);

	localparam int N  = adc_seq_pkg::TGT_N;
	localparam int IW = adc_seq_pkg::TGT_IDX_W;

	// Sequencing state
	logic [N-1:0]  seq_en_ff;      // Targets enabled for DMA update
	logic          auto_start_ff;  // Start after sequence completes
	logic          busy_ff;        // Sequencing busy status
	logic          pend_any_ff;    // Pending seen last cycle
	// Configuration
	logic          enable_ff;      // Converter enabled
	logic          left_adj_ff;    // Left adjust
	logic          start_ev_ff;    // Start by event enabled
	logic          wprot_ff;       // Peripheral write protection
	logic          ovs_ff;         // Oversampling in use
	logic [2:0]    shift_ff;       // Averaging divider shift
	// Results and flags
	logic [15:0]   result_ff;      // Conversion result
	logic [15:0]   last_ff;        // Most recent result
	logic          ready_ff;       // Result ready flag
	logic          overrun_ff;     // Overrun flag
	logic          unread_ff;      // Result not yet read
	// Bias trim fields
	logic [2:0]    refbuf_ff;
	logic [2:0]    ladder_ff;
	logic [2:0]    comp_ff;
	// Outputs held in flops
	logic [31:0]   rdata_ff;
	logic          start_ff;
	logic          tgt_wr_ff;
	logic [3:0]    tgt_sel_ff;
	logic [31:0]   tgt_data_ff;

	// Pending vector goes out to the picker
	seq_pick_if #(.N(N), .W(IW)) pick ();

	seq_target_picker #(
		.N (N),
		.W (IW)
	) u_picker (
		.p (pick)
	);

	// Raw value laid out for software
	wire logic [15:0] placed;

	result_placer #(
		.RES_W   (adc_seq_pkg::RES_W),
		.SHIFT_W (adc_seq_pkg::SHIFT_W)
	) u_placer (
		.raw_i        (conv_data_i),
		.left_adj_i   (left_adj_ff),
		.oversample_i (ovs_ff),
		.shift_i      (shift_ff),
		.placed_o     (placed)
	);

	// Address decode
	wire logic hit_data  = addr_i == adc_seq_pkg::SEQ_DATA_OFF;
	wire logic hit_ctrl  = addr_i == adc_seq_pkg::SEQ_CTRL_OFF;
	wire logic hit_res   = addr_i == adc_seq_pkg::RESULT_OFF;
	wire logic hit_trim  = addr_i == adc_seq_pkg::BIAS_TRIM_OFF;
	wire logic hit_flags = addr_i == adc_seq_pkg::FLAGS_OFF;
	wire logic hit_cfg   = addr_i == adc_seq_pkg::CONFIG_OFF;

	// Write qualifiers; protection blocks writes to protected registers
	wire logic wr_ctrl  = we_i && hit_ctrl && !wprot_ff;
	wire logic wr_data  = we_i && hit_data && !wprot_ff;
	wire logic wr_trim  = we_i && hit_trim && !wprot_ff && !enable_ff;
	wire logic wr_flags = we_i && hit_flags;
	wire logic wr_cfg   = we_i && hit_cfg;
	wire logic rd_res   = re_i && hit_res;

	// Target enables written with the control word
	wire logic [N-1:0] ctrl_tgts = wdata_i[N-1:0];
	// A word is redirected only while a target still waits
	wire logic         redirect  = wr_data && pick.any;
	wire logic [N-1:0] done_mask = N'(1) << pick.index;
	// Sequence completes when the last pending target is served
	wire logic seq_done = busy_ff && pend_any_ff && !pick.any;
	// Triggers are held back while a sequence is still running
	wire logic sw_trig = wr_cfg && wdata_i[adc_seq_pkg::SWTRIG_BIT];
	wire logic ev_trig = start_ev_ff && start_event_i;
	wire logic auto_go = seq_done && auto_start_ff && !start_ev_ff;
	wire logic nxt_start = enable_ff && !pick.any &&
		(sw_trig || ev_trig || auto_go);

	// Register views for reads; unused bits stay zero
	wire logic [31:0] ctrl_view = {auto_start_ff, 22'h0, seq_en_ff};
	wire logic [31:0] stat_view = {busy_ff, 22'h0, pick.pending};
	wire logic [31:0] trim_view = {21'h0, refbuf_ff, 1'b0, ladder_ff,
		1'b0, comp_ff};
	wire logic [31:0] cfg_view  = {24'h0, shift_ff, ovs_ff, wprot_ff,
		start_ev_ff, left_adj_ff, enable_ff};
	logic [31:0] nxt_rdata;

	// Read mux; the data register is write-only and reads zero
	always_comb begin
		nxt_rdata = adc_seq_pkg::WORD_RST;
		if (addr_i == adc_seq_pkg::SEQ_CTRL_OFF) begin
			nxt_rdata = ctrl_view;
		end else if (addr_i == adc_seq_pkg::SEQ_STAT_OFF) begin
			nxt_rdata = stat_view;
		end else if (addr_i == adc_seq_pkg::RESULT_OFF) begin
			nxt_rdata = {16'h0, result_ff};
		end else if (addr_i == adc_seq_pkg::LAST_RES_OFF) begin
			nxt_rdata = {16'h0, last_ff};
		end else if (addr_i == adc_seq_pkg::BIAS_TRIM_OFF) begin
			nxt_rdata = trim_view;
		end else if (addr_i == adc_seq_pkg::FLAGS_OFF) begin
			nxt_rdata = {30'h0, overrun_ff, ready_ff};
		end else if (addr_i == adc_seq_pkg::CONFIG_OFF) begin
			nxt_rdata = cfg_view;
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !re_i) begin
			rdata_ff <= adc_seq_pkg::WORD_RST;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// Sequencing control; a control write restarts the sequence
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			seq_en_ff     <= '0;
			auto_start_ff <= 1'b0;
			busy_ff       <= 1'b0;
		end else if (wr_ctrl) begin
			seq_en_ff     <= ctrl_tgts;
			auto_start_ff <= wdata_i[adc_seq_pkg::AUTO_START_BIT];
			busy_ff       <= |ctrl_tgts;
		end
	end

	// Pending targets: reloaded on restart, cleared one by one
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pick.pending <= '0;
		end else if (wr_ctrl) begin
			pick.pending <= ctrl_tgts;
		end else if (redirect) begin
			pick.pending <= pick.pending & ~done_mask;
		end
	end

	// Remember whether anything was pending to spot completion
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pend_any_ff <= 1'b0;
		end else begin
			pend_any_ff <= pick.any;
		end
	end

	// Redirected word goes out to the chosen target register
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			tgt_wr_ff   <= 1'b0;
			tgt_sel_ff  <= '0;
			tgt_data_ff <= adc_seq_pkg::WORD_RST;
		end else begin
			tgt_wr_ff <= redirect;
			if (redirect) begin
				tgt_sel_ff  <= pick.index;
				tgt_data_ff <= wdata_i;
			end
		end
	end

	// Conversion start pulse, one cycle
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			start_ff <= 1'b0;
		end else begin
			start_ff <= nxt_start;
		end
	end

	// Configuration; the trigger bit is a strobe, never stored
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			enable_ff   <= 1'b0;
			left_adj_ff <= 1'b0;
			start_ev_ff <= 1'b0;
			wprot_ff    <= 1'b0;
			ovs_ff      <= 1'b0;
			shift_ff    <= '0;
		end else if (wr_cfg) begin
			enable_ff   <= wdata_i[adc_seq_pkg::EN_BIT];
			left_adj_ff <= wdata_i[adc_seq_pkg::LADJ_BIT];
			start_ev_ff <= wdata_i[adc_seq_pkg::STARTEV_BIT];
			wprot_ff    <= wdata_i[adc_seq_pkg::WPROT_BIT];
			ovs_ff      <= wdata_i[adc_seq_pkg::OVS_BIT];
			shift_ff    <= wdata_i[adc_seq_pkg::SHIFT_LSB +: 3];
		end
	end

	// Bias trim; locked while enabled so the analog bias never jumps
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			refbuf_ff <= '0;
			ladder_ff <= '0;
			comp_ff   <= '0;
		end else if (wr_trim) begin
			refbuf_ff <= wdata_i[adc_seq_pkg::REFBUF_LSB +: 3];
			ladder_ff <= wdata_i[adc_seq_pkg::LADDER_LSB +: 3];
			comp_ff   <= wdata_i[adc_seq_pkg::COMP_LSB +: 3];
		end
	end

	// Result and last result capture the placed value together
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			result_ff <= adc_seq_pkg::HALF_RST;
			last_ff   <= adc_seq_pkg::HALF_RST;
		end else if (conv_valid_i) begin
			result_ff <= placed;
			last_ff   <= placed;
		end
	end

	// Flags; a new result beats a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ready_ff   <= 1'b0;
			overrun_ff <= 1'b0;
			unread_ff  <= 1'b0;
		end else begin
			ready_ff <= conv_valid_i || (ready_ff && !rd_res &&
				!(wr_flags && wdata_i[adc_seq_pkg::READY_BIT]));
			overrun_ff <= (conv_valid_i && unread_ff) ||
				(overrun_ff &&
				!(wr_flags && wdata_i[adc_seq_pkg::OVERRUN_BIT]));
			unread_ff <= conv_valid_i || (unread_ff && !rd_res);
		end
	end

	assign rdata_o                 = rdata_ff;
	assign conv_start_o            = start_ff;
	assign tgt_wr_o                = tgt_wr_ff;
	assign tgt_sel_o               = tgt_sel_ff;
	assign tgt_data_o              = tgt_data_ff;
	assign enable_o                = enable_ff;
	assign left_adjust_o           = left_adj_ff;
	assign reference_buffer_bias_o = refbuf_ff;
	assign ladder_amplifier_bias_o = ladder_ff;
	assign comparator_bias_o       = comp_ff;
	assign result_ready_flag_o     = ready_ff;
	assign overrun_o               = overrun_ff;

	// Checks on the bank's own behaviour
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// Sequence finishing: last pending word redirected, none left
	sequence s_last_word;
		redirect && $countones(pick.pending) == 1;
	endsequence

	sequence s_auto_armed;
		busy_ff && auto_start_ff && !start_ev_ff && enable_ff;
	endsequence

	a_busy_on_start: assert property (
		we_i && hit_ctrl && !wprot_ff && |wdata_i[8:0] |=> busy_ff)
		else $error("busy not set after sequencing enabled");

	a_busy_on_stop: assert property (
		wr_ctrl && wdata_i[8:0] == 9'h000 |=> !stat_view[31])
		else $error("busy not cleared after sequencing disabled");

	a_pend_load: assert property (
		wr_ctrl |=> pick.pending == $past(wdata_i[8:0]))
		else $error("pending bits not loaded from control word");

	a_seq_redirect: assert property (
		redirect |=> tgt_wr_o && tgt_sel_o == $past(pick.index) &&
			!pick.pending[$past(pick.index)] &&
			tgt_data_o == $past(wdata_i))
		else $error("sequence word not sent to first pending target");

	a_auto_start: assert property (
		s_auto_armed and s_last_word |=> ##1 conv_start_o)
		else $error("no automatic start after sequence end");

	a_left_place: assert property (
		conv_valid_i && left_adj_ff && !ovs_ff |=>
			result_ff == {$past(conv_data_i[11:0]), 4'h0})
		else $error("left adjusted result misplaced");

	a_right_place: assert property (
		conv_valid_i && !left_adj_ff && !ovs_ff |=>
			result_ff == {4'h0, $past(conv_data_i[11:0])})
		else $error("right adjusted result misplaced");

	a_ovs_place: assert property (
		conv_valid_i && ovs_ff |=>
			result_ff == ($past(conv_data_i) >> $past(shift_ff)))
		else $error("oversampled result misplaced");

	a_result_read: assert property (
		rd_res ##1 !re_i |-> rdata_o == {16'h0, $past(result_ff)} ##1
			rdata_o == 32'h0)
		else $error("result read data wrong or held too long");

	a_last_follow: assert property (
		conv_valid_i |=> last_ff == result_ff)
		else $error("last result differs from result");

	a_trim_lock: assert property (
		we_i && hit_trim && (enable_ff || wprot_ff) |=>
			$stable(trim_view))
		else $error("bias trim changed while locked");

	a_ready_clear: assert property (
		rd_res && !conv_valid_i |=> !ready_ff)
		else $error("ready flag survived a result read");

	a_overrun_set: assert property (
		conv_valid_i && unread_ff |=> overrun_ff [*2] or
			(overrun_ff ##1 1'b1))
		else $error("overrun not flagged on unread result");

endmodule : adc_result_sequence_status_regs

// [design/adc_seq_pkg.sv]
// Shared constants for the converter sequencing and result register bank
package adc_seq_pkg;

	// Register bus geometry
	localparam int          ADDR_W         = 8;
	localparam int          DATA_W         = 32;
	localparam int          RES_W          = 16;
	localparam int          TGT_N          = 9;   // Sequenced targets
	localparam int          TGT_IDX_W      = 4;
	localparam int          TRIM_W         = 3;
	localparam int          SHIFT_W        = 3;

	// Register offsets (byte addresses)
	localparam logic [7:0]  SEQ_DATA_OFF   = 8'h34;
	localparam logic [7:0]  SEQ_CTRL_OFF   = 8'h38;
	localparam logic [7:0]  SEQ_STAT_OFF   = 8'h3c;
	localparam logic [7:0]  RESULT_OFF     = 8'h40;
	localparam logic [7:0]  LAST_RES_OFF   = 8'h44;
	localparam logic [7:0]  BIAS_TRIM_OFF  = 8'h48;
	localparam logic [7:0]  FLAGS_OFF      = 8'h4c;
	localparam logic [7:0]  CONFIG_OFF     = 8'h50;

	// Sequencing control and status fields
	localparam int          AUTO_START_BIT = 31;
	localparam int          BUSY_BIT       = 31;
	localparam int          TGT_MSB        = 8;   // Offset correction

	// Bias trim field positions (lsb of each 3-bit field)
	localparam int          REFBUF_LSB     = 8;
	localparam int          LADDER_LSB     = 4;
	localparam int          COMP_LSB       = 0;

	// Flag register bits, write one to clear
	localparam int          READY_BIT      = 0;
	localparam int          OVERRUN_BIT    = 1;

	// Configuration register fields
	localparam int          EN_BIT         = 0;
	localparam int          LADJ_BIT       = 1;
	localparam int          STARTEV_BIT    = 2;
	localparam int          WPROT_BIT      = 3;
	localparam int          OVS_BIT        = 4;
	localparam int          SHIFT_LSB      = 5;
	localparam int          SWTRIG_BIT     = 8;

	// Reset values
	localparam logic [31:0] WORD_RST       = 32'h0000_0000;
	localparam logic [15:0] HALF_RST       = 16'h0000;

endpackage : adc_seq_pkg

// [design/result_placer.sv]
// Places a raw conversion value into the 16-bit result layout
module result_placer #(
	parameter int RES_W   = 16,
	parameter int SHIFT_W = 3
) (
	input  wire logic [RES_W-1:0]   raw_i,        // Core value or sum
	input  wire logic               left_adj_i,   // Left adjust select
	input  wire logic               oversample_i, // Averaging in use
	input  wire logic [SHIFT_W-1:0] shift_i,      // Averaging divider
	output      logic [RES_W-1:0]   placed_o
);

	if (RES_W != 16) begin : g_bad_width
		$error("result_placer: only a 16-bit result layout is served");
	end

	// Three candidate layouts, chosen below
	wire logic [RES_W-1:0] ovs_val   = raw_i >> shift_i;
	wire logic [RES_W-1:0] left_val  = {raw_i[11:0], 4'h0};
	wire logic [RES_W-1:0] right_val = {4'h0, raw_i[11:0]};

	// Oversampling placement wins over left adjust
	assign placed_o = oversample_i ? ovs_val :
		(left_adj_i ? left_val : right_val);

endmodule : result_placer

// [design/seq_pick_if.sv]
// Pending-target vector and its first-pending pick, shared with the picker
interface seq_pick_if #(
	parameter int N = 9,
	parameter int W = 4
);
	logic [N-1:0] pending;   // Targets still awaiting a DMA word
	logic         any;       // At least one target pending
	logic [W-1:0] index;     // Lowest pending target

	modport owner  (output pending, input  any, input  index);
	modport picker (input  pending, output any, output index);
endinterface : seq_pick_if

// [design/seq_target_picker.sv]
// Picks the first pending sequencing target, lowest bit first
module seq_target_picker #(
	parameter int N = 9,
	parameter int W = 4
) (
	seq_pick_if.picker p
);

	// The index must be able to name every target
	if (N < 1 || N > (1 << W)) begin : g_bad_size
		$error("seq_target_picker: N does not fit index width W");
	end

	// Lowest set bit; input control sits at bit 0 and goes first
	function automatic logic [W-1:0] first_set(input logic [N-1:0] v);
		logic [W-1:0] r;
		r = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = W'(i);
			end
		end
		return r;
	endfunction : first_set

	assign p.any   = |p.pending;
	assign p.index = first_set(p.pending);

endmodule : seq_target_picker

// [dv/adc_result_sequence_status_regs_tb.sv]
// Self-checking bench for the sequencing, result and trim register bank
module adc_result_sequence_status_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk;         // 100 MHz bench clock
	logic        rst_n;       // Synchronous reset, active low
	logic [7:0]  addr;        // Register address
	logic [31:0] wdata;       // Register write data
	logic        we;          // Write strobe
	logic        re;          // Read strobe
	logic [31:0] rdata;       // Read data, cycle after re only
	logic        conv_valid;  // Core answer strobe
	logic [15:0] conv_data;   // Core answer value
	logic        start_event; // Event start request
	logic        conv_start;  // Start pulse to the core
	logic        tgt_wr;      // Target update pulse
	logic [3:0]  tgt_sel;     // Target number
	logic [31:0] tgt_data;    // Target word
	logic        enable;      // Converter enable
	logic        left_adjust; // Left adjust setting
	logic [2:0]  refbuf_bias; // Trim fields
	logic [2:0]  ladder_bias;
	logic [2:0]  comp_bias;
	logic        ready_flag;  // Result ready flag
	logic        overrun;     // Overrun flag
	logic [3:0]  lat;         // Core answer delay
	logic [15:0] sample;      // Next core value
	logic [35:0] tgt_q[$];    // Observed target updates, sel and word
	int          n_conv;      // Core answers seen
	int          base;        // Answer count before a trigger
	int          num_errors;
	int          num_checks;
	// Sequence words, the targets they must reach, status after each
	logic [31:0] word_tab[3] = '{32'h1111_0000, 32'h2222_0007, 32'h3333_0008};
	logic [31:0] sel_tab[3]  = '{32'h0000_0000, 32'h0000_0007, 32'h0000_0008};
	logic [31:0] stat_tab[3] = '{32'h8000_0180, 32'h8000_0100, 32'h8000_0000};
	// Placement modes: right, left, averaged, averaged with left adjust
	logic [31:0] cfg_tab[4]  = '{32'h0000_0001, 32'h0000_0003,
		32'h0000_0051, 32'h0000_0053};
	logic [15:0] smp_tab[4]  = '{16'h0ABC, 16'h0ABC, 16'hFFFC, 16'hFFFC};
	logic [31:0] res_tab[4]  = '{32'h0000_0ABC, 32'h0000_ABC0,
		32'h0000_3FFF, 32'h0000_3FFF};

	adc_result_sequence_status_regs dut_u (
		.clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
		.we_i(we), .re_i(re), .rdata_o(rdata), .conv_valid_i(conv_valid),
		.conv_data_i(conv_data), .start_event_i(start_event),
		.conv_start_o(conv_start), .tgt_wr_o(tgt_wr), .tgt_sel_o(tgt_sel),
		.tgt_data_o(tgt_data), .enable_o(enable),
		.left_adjust_o(left_adjust), .reference_buffer_bias_o(refbuf_bias),
		.ladder_amplifier_bias_o(ladder_bias), .comparator_bias_o(comp_bias),
		.result_ready_flag_o(ready_flag), .overrun_o(overrun)
	);

	conv_core_model core_u (
		.clk_i(clk), .rst_n_i(rst_n), .start_i(conv_start), .lat_i(lat),
		.sample_i(sample), .valid_o(conv_valid), .data_o(conv_data)
	);

	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Log target updates and core answers as they happen
	always @(posedge clk) begin
		if (tgt_wr === 1'b1) begin
			tgt_q.push_back({tgt_sel, tgt_data});
		end
		if (conv_valid === 1'b1) begin
			n_conv <= n_conv + 1;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		we    <= 1'b1;
		@(posedge clk);
		we    <= 1'b0;
	endtask : wr

	// Read data stands only in the cycle after the strobe, so look there
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		re   <= 1'b1;
		@(posedge clk);
		re   <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : rchk

	// Bounded wait for exactly one new core answer
	task automatic wait_conv();
		int k;
		k = 0;
		while (n_conv <= base && k < 100) begin
			@(posedge clk);
			#1;
			k++;
		end
		chk(32'(n_conv - base), 32'h0000_0001);
	endtask : wait_conv

	// Software trigger rides on a configuration write
	task automatic trig(input logic [31:0] cfg);
		base = n_conv;
		wr(adc_seq_pkg::CONFIG_OFF, cfg | 32'h0000_0100);
		wait_conv();
	endtask : trig

	task automatic end_of_test();
		$display("checks=%0d errors=%0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	// Cuts a hang short; the tests take about two hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		end_of_test();
	end

	initial begin
		rst_n = 1'b0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		we = 1'b0;
		re = 1'b0;
		start_event = 1'b0;
		lat = 4'h1;
		sample = 16'h0000;
		num_errors = 0;
		num_checks = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		// Reset values of the four registers, then unmapped space
		for (int i = 0; i < 4; i++) begin
			rchk(adc_seq_pkg::SEQ_STAT_OFF + 8'(4 * i), 32'h0000_0000);
		end
		rchk(8'h60, 32'h0000_0000);
		$display("test reset done");
		// Trim copy, then write protect and enable both refuse writes
		wr(adc_seq_pkg::BIAS_TRIM_OFF, 32'hFFFF_FFFF);
		rchk(adc_seq_pkg::BIAS_TRIM_OFF, 32'h0000_0777);
		chk(32'({refbuf_bias, ladder_bias, comp_bias}), 32'h0000_01FF);
		wr(adc_seq_pkg::CONFIG_OFF, 32'h0000_0008);
		wr(adc_seq_pkg::BIAS_TRIM_OFF, 32'h0000_0000);
		wr(adc_seq_pkg::SEQ_CTRL_OFF, 32'h0000_0001);
		rchk(adc_seq_pkg::BIAS_TRIM_OFF, 32'h0000_0777);
		rchk(adc_seq_pkg::SEQ_STAT_OFF, 32'h0000_0000);
		wr(adc_seq_pkg::CONFIG_OFF, 32'h0000_0001);
		wr(adc_seq_pkg::BIAS_TRIM_OFF, 32'h0000_0000);
		rchk(adc_seq_pkg::BIAS_TRIM_OFF, 32'h0000_0777);
		chk(32'(enable), 32'h0000_0001);
		$display("test trim done");
		// Three targets with auto start, slow core
		lat <= 4'h6;
		sample <= 16'h0123;
		wr(adc_seq_pkg::SEQ_CTRL_OFF, 32'h8000_0181);
		rchk(adc_seq_pkg::SEQ_STAT_OFF, 32'h8000_0181);
		base = n_conv;
		for (int i = 0; i < 3; i++) begin
			wr(adc_seq_pkg::SEQ_DATA_OFF, word_tab[i]);
			rchk(adc_seq_pkg::SEQ_STAT_OFF, stat_tab[i]);
		end
		wait_conv();
		chk(32'(tgt_q.size()), 32'h0000_0003);
		for (int i = 0; i < 3; i++) begin
			chk(32'(tgt_q[i][35:32]), sel_tab[i]);
			chk(tgt_q[i][31:0], word_tab[i]);
		end
		rchk(adc_seq_pkg::RESULT_OFF, 32'h0000_0123);
		wr(adc_seq_pkg::SEQ_CTRL_OFF, 32'h0000_0000);
		rchk(adc_seq_pkg::SEQ_STAT_OFF, 32'h0000_0000);
		wr(adc_seq_pkg::SEQ_DATA_OFF, 32'hDEAD_0000);
		rchk(adc_seq_pkg::SEQ_STAT_OFF, 32'h0000_0000);
		chk(32'(tgt_q.size()), 32'h0000_0003);
		$display("test sequence done");
		// Result placement in every mode; reading the result clears ready
		lat <= 4'h1;
		for (int i = 0; i < 4; i++) begin
			sample <= smp_tab[i];
			trig(cfg_tab[i]);
			chk(32'(left_adjust), 32'(cfg_tab[i][1]));
			rchk(adc_seq_pkg::LAST_RES_OFF, res_tab[i]);
			chk(32'(ready_flag), 32'h0000_0001);
			rchk(adc_seq_pkg::RESULT_OFF, res_tab[i]);
			chk(32'(ready_flag), 32'h0000_0000);
		end
		chk(32'(overrun), 32'h0000_0000);
		wr(adc_seq_pkg::RESULT_OFF, 32'hFFFF_FFFF);
		rchk(adc_seq_pkg::RESULT_OFF, res_tab[3]);
		$display("test placement done");
		// Unread result overwritten, then write-one clears both flags
		trig(32'h0000_0001);
		trig(32'h0000_0001);
		chk(32'(overrun), 32'h0000_0001);
		rchk(adc_seq_pkg::FLAGS_OFF, 32'h0000_0003);
		wr(adc_seq_pkg::FLAGS_OFF, 32'h0000_0003);
		rchk(adc_seq_pkg::FLAGS_OFF, 32'h0000_0000);
		$display("test overrun done");
		// Event start, and auto start held back while event start is on
		wr(adc_seq_pkg::CONFIG_OFF, 32'h0000_0005);
		base = n_conv;
		start_event <= 1'b1;
		@(posedge clk);
		start_event <= 1'b0;
		wait_conv();
		// Core still offers the averaged sample; plain right adjust keeps 12 bits
		rchk(adc_seq_pkg::RESULT_OFF, 32'h0000_0FFC);
		base = n_conv;
		wr(adc_seq_pkg::SEQ_CTRL_OFF, 32'h8000_0001);
		wr(adc_seq_pkg::SEQ_DATA_OFF, 32'h0000_0055);
		repeat (12) @(posedge clk);
		chk(32'(n_conv - base), 32'h0000_0000);
		wr(adc_seq_pkg::SEQ_CTRL_OFF, 32'h0000_0000);
		$display("test start done");
		end_of_test();
	end
endmodule : adc_result_sequence_status_regs_tb

// [dv/conv_core_model.sv]
// Behavioural converter core that answers start pulses from the bank
module conv_core_model (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        start_i,  // Start pulse from the bank
	input  wire logic [3:0]  lat_i,    // Answer delay in cycles, 1 or more
	input  wire logic [15:0] sample_i, // Value of the next conversion
	output      logic        valid_o,  // One-cycle answer strobe
	output      logic [15:0] data_o    // Value, meaningful with valid_o only
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [3:0] wait_ff; // Cycles left, 0 when idle

	// Count a conversion down; a new start restarts the count
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wait_ff <= 4'h0;
			valid_o <= 1'b0;
			data_o  <= 16'h0000;
		end else begin
			valid_o <= (wait_ff == 4'h1);
			if (start_i) begin
				wait_ff <= lat_i;
			end else if (wait_ff != 4'h0) begin
				wait_ff <= wait_ff - 4'h1;
			end
			// Data toggles off the answer cycle so a stale sample never matches
			data_o <= (wait_ff == 4'h1) ? sample_i : ~data_o;
		end
	end
endmodule : conv_core_model
